// File: include/scs_pkg.sv
/*
  scs_pkg: register map, field layout, reset values and loop constants
  for the system clock source select and PLL block.
  Assumes a single 32-bit AHB-Lite slave port and one 20 MHz bus clock.
*/
package scs_pkg;

  // ---------------------------------------------------------------
  // clock and bus
  // ---------------------------------------------------------------
  localparam int HCLK_HZ = 20000000;
  localparam logic [7:0] ADDR_SYSCTL = 8'h00;
  localparam logic [7:0] ADDR_PLLCTL = 8'h04;
  localparam logic [7:0] ADDR_PRESCL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // ---------------------------------------------------------------
  // source select and band codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SRC_WAKEUP = 2'b00;
  localparam logic [1:0] SRC_PLL = 2'b10;
  localparam logic [1:0] SRC_DIRECT = 2'b11;
  localparam logic [1:0] BAND_LOWER = 2'b00;
  localparam logic [1:0] BAND_UPPER = 2'b01;

  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int SEL_LSB = 0;
  localparam int BYPASS_BIT = 0;
  localparam int REFSEL_BIT = 1;
  localparam int BAND_LSB = 2;
  localparam int IN_DIV_LSB = 4;
  localparam int IN_DIV_W = 4;
  localparam int FB_MUL_LSB = 8;
  localparam int FB_MUL_W = 7;
  localparam int OUT_DIV_LSB = 16;
  localparam int OUT_DIV_W = 7;
  localparam int PRE_DIV_LSB = 0;
  localparam int PRE_DIV_W = 10;
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_PLLON_BIT = 2;
  localparam int STAT_LOCK_BIT = 3;
  localparam int STAT_STEP_LSB = 16;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_RESET = SRC_WAKEUP;
  localparam logic [31:0] PLLCTL_RESET = 32'h0000_0001;
  localparam logic [31:0] PRESCL_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // numeric oscillator model of the vco
  // ---------------------------------------------------------------
  localparam int NCO_W = 16;
  localparam logic [NCO_W-1:0] LOWER_STEP_MIN = 16'h0400;
  localparam logic [NCO_W-1:0] LOWER_STEP_MAX = 16'h1000;
  localparam logic [NCO_W-1:0] UPPER_STEP_MIN = 16'h0C00;
  localparam logic [NCO_W-1:0] UPPER_STEP_MAX = 16'h2000;
  localparam logic [7:0] LOCK_GOOD = 8'h10;

endpackage : scs_pkg

// File: design/scs_edge_divider.sv
/*
  scs_edge_divider: divides a sampled clock level by (field + 1),
  counting rising edges of the input and giving a near square output.
  Assumes the input rise is a one-cycle pulse on hclk.
*/
`timescale 1ns/1ps
module scs_edge_divider #(
  parameter int WIDTH = 7
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // input clock as level plus rising-edge pulse
  input wire logic in_level,
  input wire logic in_rise,
  // divisor minus one
  input wire logic [WIDTH-1:0] divisor_field,
  // divided clock
  output logic out_level,
  output logic out_rise
);
  import scs_pkg::*;

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic [WIDTH:0] half;

  assign half = ({1'b0, divisor_field} + {{WIDTH{1'b0}}, 1'b1}) >> 1;

  always_comb
  begin
    count_next = count_reg;
    if (in_rise)
    begin
      if (count_reg >= divisor_field)
        count_next = '0;
      else
        count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  // divide by one keeps the input duty cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_level <= 1'b0;
      out_rise <= 1'b0;
    end
    else if (divisor_field == '0)
    begin
      out_level <= in_level;
      out_rise <= in_rise;
    end
    else
    begin
      out_level <= ({1'b0, count_next} < half);
      out_rise <= in_rise && (count_next == '0);
    end
  end

endmodule : scs_edge_divider

// File: design/scs_clock_control.sv
/*
  scs_clock_control: system clock source select with pll, prescaler,
  direct drive and wakeup modes, configured over AHB-Lite.
  Assumes every clock pin toggles well below a quarter of hclk; the pll
  is a numeric oscillator model on hclk with a frequency-locked loop.
*/
// Behaviour
// - select 10 and no bypass runs pll
// - divisors are field plus one each
// - pll reference is crystal or internal source
// - pll frequency moves gradually, no jumps
// - system clock is vco divided by K2
// - two-bit band code picks vco range
// - select 00 takes wakeup clock directly
// - select 11 passes direct clock pin
// - bypass divides oscillator by K1 up to 1024
`timescale 1ns/1ps
module scs_clock_control (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // clock pins
  input wire logic crystal_input_pin,
  input wire logic internal_clock_in,
  input wire logic wakeup_clock_in,
  input wire logic direct_clock_input_pin,
  // generated clock
  output logic sys_clock_out,
  output logic pll_enable,
  output logic pll_locked
);
  import scs_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [1:0] clock_source_select_reg;
  logic [31:0] pll_control_reg_zero;
  logic [PRE_DIV_W-1:0] prescaler_divider_reg;
  logic oscillator_bypass_bit;
  logic ref_select;
  logic [1:0] oscillator_band_select;
  logic [IN_DIV_W-1:0] pll_input_divider_field;
  logic [FB_MUL_W-1:0] pll_feedback_multiplier_field;
  logic [OUT_DIV_W-1:0] pll_output_divider_field;

  assign oscillator_bypass_bit = pll_control_reg_zero[BYPASS_BIT];
  assign ref_select = pll_control_reg_zero[REFSEL_BIT];
  assign oscillator_band_select = pll_control_reg_zero[BAND_LSB +: 2];
  assign pll_input_divider_field = pll_control_reg_zero[IN_DIV_LSB +: IN_DIV_W];
  assign pll_feedback_multiplier_field = pll_control_reg_zero[FB_MUL_LSB +: FB_MUL_W];
  assign pll_output_divider_field = pll_control_reg_zero[OUT_DIV_LSB +: OUT_DIV_W];

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic addr_phase;
  logic [31:0] read_word;
  logic [31:0] status_word;

  assign addr_phase = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb
  begin
    case (haddr[7:0])
      ADDR_SYSCTL: read_word = {30'h0000_0000, clock_source_select_reg};
      ADDR_PLLCTL: read_word = pll_control_reg_zero;
      ADDR_PRESCL: read_word = {{(32-PRE_DIV_W){1'b0}}, prescaler_divider_reg};
      ADDR_STATUS: read_word = status_word;
      default: read_word = 32'h0000_0000;
    endcase
    if (haddr[31:8] != 24'h00_0000)
      read_word = 32'h0000_0000;
  end

  // read data is sampled in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= addr_phase && hwrite && (haddr[31:8] == 24'h00_0000);
      if (addr_phase)
      begin
        wr_addr_reg <= haddr[7:0];
        hrdata <= hwrite ? 32'h0000_0000 : read_word;
      end
    end
  end

  // fields take effect together, so a single word write switches cleanly
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clock_source_select_reg <= SEL_RESET;
      pll_control_reg_zero <= PLLCTL_RESET;
      prescaler_divider_reg <= PRESCL_RESET[PRE_DIV_W-1:0];
    end
    else if (wr_pend_reg)
    begin
      case (wr_addr_reg)
        ADDR_SYSCTL: clock_source_select_reg <= hwdata[SEL_LSB +: 2];
        ADDR_PLLCTL: pll_control_reg_zero <= hwdata & 32'h007F_7FFF;
        ADDR_PRESCL: prescaler_divider_reg <= hwdata[PRE_DIV_LSB +: PRE_DIV_W];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers and edge filters
  // ---------------------------------------------------------------
  logic [3:0] pin_in;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] level_reg;
  logic [3:0] rise;

  assign pin_in = {direct_clock_input_pin, wakeup_clock_in, internal_clock_in,
                   crystal_input_pin};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pin
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          sync3_reg[g] <= 1'b0;
          level_reg[g] <= 1'b0;
        end
        else
        begin
          sync1_reg[g] <= pin_in[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
          if (sync2_reg[g] == sync3_reg[g])
            level_reg[g] <= sync3_reg[g];
        end
      end
      assign rise[g] = (sync2_reg[g] == sync3_reg[g]) && sync3_reg[g] && !level_reg[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // oscillator selection and prescaler
  // ---------------------------------------------------------------
  logic osc_level;
  logic osc_rise;
  logic k1_level;

  assign osc_level = ref_select ? level_reg[1] : level_reg[0];
  assign osc_rise = ref_select ? rise[1] : rise[0];

  scs_edge_divider #(.WIDTH(PRE_DIV_W)) u_k1_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_level(osc_level),
    .in_rise(osc_rise),
    .divisor_field(prescaler_divider_reg),
    .out_level(k1_level),
    .out_rise()
  );

  // ---------------------------------------------------------------
  // pll: input divider, oscillator, feedback and output dividers
  // ---------------------------------------------------------------
  logic ref_div_rise;
  logic [NCO_W-1:0] acc_reg;
  logic [NCO_W-1:0] step_reg;
  logic vco_level;
  logic vco_prev_reg;
  logic vco_rise;
  logic fb_rise;
  logic [1:0] fb_seen_reg;
  logic [7:0] good_count_reg;
  logic [NCO_W-1:0] step_min;
  logic [NCO_W-1:0] step_max;
  logic k2_level;

  assign pll_enable = (clock_source_select_reg == SRC_PLL) && !oscillator_bypass_bit;
  assign vco_level = acc_reg[NCO_W-1];
  assign vco_rise = vco_level && !vco_prev_reg;
  assign step_min = (oscillator_band_select == BAND_UPPER) ? UPPER_STEP_MIN
                                                           : LOWER_STEP_MIN;
  assign step_max = (oscillator_band_select == BAND_UPPER) ? UPPER_STEP_MAX
                                                           : LOWER_STEP_MAX;

  scs_edge_divider #(.WIDTH(IN_DIV_W)) u_p_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_level(osc_level),
    .in_rise(osc_rise && pll_enable),
    .divisor_field(pll_input_divider_field),
    .out_level(),
    .out_rise(ref_div_rise)
  );

  scs_edge_divider #(.WIDTH(FB_MUL_W)) u_n_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_level(vco_level),
    .in_rise(vco_rise),
    .divisor_field(pll_feedback_multiplier_field),
    .out_level(),
    .out_rise(fb_rise)
  );

  scs_edge_divider #(.WIDTH(OUT_DIV_W)) u_k2_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_level(vco_level),
    .in_rise(vco_rise),
    .divisor_field(pll_output_divider_field),
    .out_level(k2_level),
    .out_rise()
  );

  // oscillator stays parked while the pll is off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_reg <= '0;
      vco_prev_reg <= 1'b0;
    end
    else if (!pll_enable)
    begin
      acc_reg <= '0;
      vco_prev_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_reg + step_reg;
      vco_prev_reg <= vco_level;
    end
  end

  // feedback edges seen per divided reference period
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fb_seen_reg <= 2'b00;
    else if (!pll_enable)
      fb_seen_reg <= 2'b00;
    else if (ref_div_rise)
      fb_seen_reg <= {1'b0, fb_rise};
    else if (fb_rise && fb_seen_reg != 2'b11)
      fb_seen_reg <= fb_seen_reg + 2'b01;
  end

  // one unit of step per reference period, or per hclk cycle while outside the band: slow, but never a jump
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      step_reg <= LOWER_STEP_MIN;
    else if (!pll_enable)
      step_reg <= step_min;
    else if (step_reg < step_min)
      step_reg <= step_reg + {{(NCO_W-1){1'b0}}, 1'b1};
    else if (step_reg > step_max)
      step_reg <= step_reg - {{(NCO_W-1){1'b0}}, 1'b1};
    else if (ref_div_rise && fb_seen_reg == 2'b00 && step_reg < step_max)
      step_reg <= step_reg + {{(NCO_W-1){1'b0}}, 1'b1};
    else if (ref_div_rise && fb_seen_reg > 2'b01 && step_reg > step_min)
      step_reg <= step_reg - {{(NCO_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      good_count_reg <= 8'h00;
    else if (!pll_enable)
      good_count_reg <= 8'h00;
    else if (ref_div_rise)
    begin
      if (fb_seen_reg != 2'b01)
        good_count_reg <= 8'h00;
      else if (good_count_reg != LOCK_GOOD)
        good_count_reg <= good_count_reg + 8'h01;
    end
  end

  assign pll_locked = pll_enable && (good_count_reg == LOCK_GOOD);

  // ---------------------------------------------------------------
  // system clock selection
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sys_clock_out <= 1'b0;
    else
    begin
      case (clock_source_select_reg)
        SRC_WAKEUP: sys_clock_out <= level_reg[2];
        SRC_DIRECT: sys_clock_out <= level_reg[3];
        SRC_PLL: sys_clock_out <= oscillator_bypass_bit ? k1_level : k2_level;
        default: sys_clock_out <= level_reg[2];
      endcase
    end
  end

  assign status_word = {step_reg, 12'h000, pll_locked, pll_enable, clock_source_select_reg};

endmodule : scs_clock_control

// File: sim/scs_clock_control_asserts.sv
/*
  scs_clock_control_asserts: port-level checker for the clock control block.
  Assumes hready is tied to hreadyout and writes are single words.
*/
`timescale 1ns/1ps
module scs_clock_control_asserts (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // clocks
  input wire logic wakeup_clock_in,
  input wire logic direct_clock_input_pin,
  input wire logic sys_clock_out,
  input wire logic pll_enable,
  input wire logic pll_locked
);
  import scs_pkg::*;
  // ---------------------------------------------------------------
  // shadow of select and bypass, taken from bus writes
  // ---------------------------------------------------------------
  logic wr_ph;
  logic [7:0] wa;
  logic [1:0] sel_q;
  logic byp_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph <= 1'b0;
      wa <= 8'h00;
    end
    else
    begin
      wr_ph <= hsel && htrans[1] && hready && hwrite && haddr[31:8] == 24'h0;
      wa <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sel_q <= SEL_RESET;
      byp_q <= PLLCTL_RESET[BYPASS_BIT];
    end
    else if (wr_ph && wa == ADDR_SYSCTL)
      sel_q <= hwdata[1:0];
    else if (wr_ph && wa == ADDR_PLLCTL)
      byp_q <= hwdata[BYPASS_BIT];
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
  unmapped_zero_a: assert property (hsel && htrans[1] && hready && !hwrite
    && haddr == 32'h0000_0010 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property ($rose(hresetn) |-> !sys_clock_out && !pll_enable && !pll_locked)
    else $error("outputs active after reset");
  pll_enable_a: assert property (pll_enable == (sel_q == SRC_PLL && !byp_q))
    else $error("pll enable disagrees with select and bypass");
  lock_needs_pll_a: assert property (pll_locked |-> pll_enable)
    else $error("lock without pll enabled");
  unlock_off_a: assert property (!pll_enable ##1 !pll_enable |-> !pll_locked)
    else $error("lock kept after pll disabled");
  wakeup_follow_a: assert property ((sel_q == SRC_WAKEUP && $stable(wakeup_clock_in))[*8]
    |-> sys_clock_out == wakeup_clock_in)
    else $error("system clock not following wakeup clock");
  direct_follow_a: assert property ((sel_q == SRC_DIRECT && $stable(direct_clock_input_pin))[*6]
    |-> sys_clock_out == direct_clock_input_pin)
    else $error("system clock not following direct pin");
endmodule : scs_clock_control_asserts

bind scs_clock_control scs_clock_control_asserts u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .wakeup_clock_in,
  .direct_clock_input_pin, .sys_clock_out, .pll_enable, .pll_locked);

// File: sim/scs_clock_sources.sv
/*
  scs_clock_sources: free running crystal, internal, wakeup and direct clocks.
  Assumes half periods of several hclk cycles, as the synchronisers need.
*/
`timescale 1ns/1ps
module scs_clock_sources #(
  parameter int CRYS_HALF_NS = 200,
  parameter int INT_HALF_NS = 300,
  parameter int WAKE_HALF_NS = 1000,
  parameter int DIRECT_HALF_NS = 400
) (
  // clock sources
  output logic crystal_input_pin,
  output logic internal_clock_in,
  output logic wakeup_clock_in,
  output logic direct_clock_input_pin
);
  // odd offsets keep every source out of phase with hclk
  initial
  begin
    crystal_input_pin = 1'b0;
    #7;
    forever #(CRYS_HALF_NS) crystal_input_pin = ~crystal_input_pin;
  end
  initial
  begin
    internal_clock_in = 1'b0;
    #11;
    forever #(INT_HALF_NS) internal_clock_in = ~internal_clock_in;
  end
  initial
  begin
    wakeup_clock_in = 1'b0;
    #13;
    forever #(WAKE_HALF_NS) wakeup_clock_in = ~wakeup_clock_in;
  end
  initial
  begin
    direct_clock_input_pin = 1'b0;
    #17;
    forever #(DIRECT_HALF_NS) direct_clock_input_pin = ~direct_clock_input_pin;
  end
endmodule : scs_clock_sources

// File: sim/testbench.sv
/*
  testbench: drives the clock control block over AHB-Lite and counts
  system clock edges. Assumes source periods of 8, 12, 40, 16 hclk.
*/
`timescale 1ns/1ps
module testbench;
  import scs_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic crys, intc, wake, dclk, sys_clk, pll_en, pll_lk;
  int fails, n_compared, s1, s2, k;
  scs_clock_sources src (.crystal_input_pin(crys), .internal_clock_in(intc),
    .wakeup_clock_in(wake), .direct_clock_input_pin(dclk));
  scs_clock_control DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .crystal_input_pin(crys),
    .internal_clock_in(intc), .wakeup_clock_in(wake), .direct_clock_input_pin(dclk),
    .sys_clock_out(sys_clk), .pll_enable(pll_en), .pll_locked(pll_lk));
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // ---------------------------------------------------------------
  // compare and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic check_in(input string name, input int v, input int lo, input int hi);
    check(name, (v >= lo && v <= hi) ? 32'(lo) : 32'(v), 32'(lo));
  endtask : check_in
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0);
    check(name, q, exp);
  endtask : rd_chk
  // counts system clock rises over n cycles after the switch settles
  task automatic rate(input string name, input int n, input int per);
    int c;
    logic p;
    repeat (60) @(negedge hclk);
    c = 0;
    p = sys_clk;
    repeat (n)
    begin
      @(negedge hclk);
      if (sys_clk && !p) c++;
      p = sys_clk;
    end
    check_in(name, c, n / per - 1, n / per + 1);
  endtask : rate
  task automatic wait_lock();
    k = 0;
    while (pll_lk !== 1'b1 && k < 8000)
    begin
      @(negedge hclk);
      k++;
    end
    check("pll_locked", pll_lk, 1'b1);
  endtask : wait_lock
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (60000) @(posedge hclk);
    fails++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    fails = 0;
    n_compared = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(ADDR_SYSCTL, {30'h0, SEL_RESET}, "sysctl_reset");
    rd_chk(ADDR_PLLCTL, PLLCTL_RESET, "pllctl_reset");
    rd_chk(ADDR_PRESCL, PRESCL_RESET, "prescl_reset");
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0000_0000, "unmapped");
    rate("wakeup_rate", 2000, 40);
    bus(1'b1, ADDR_PLLCTL, 32'hFFFF_FFFF);
    rd_chk(ADDR_PLLCTL, 32'h007F_7FFF, "pllctl_fields");
    bus(1'b1, ADDR_PRESCL, 32'hFFFF_FFFF);
    rd_chk(ADDR_PRESCL, 32'h0000_03FF, "k1_max");
    bus(1'b1, ADDR_SYSCTL, {30'h0, SRC_DIRECT});
    rate("direct_rate", 2000, 16);
    // dividers first, select last, so no stray setting runs
    bus(1'b1, ADDR_PRESCL, 32'h0000_0002);
    bus(1'b1, ADDR_PLLCTL, 32'h0000_0001);
    bus(1'b1, ADDR_SYSCTL, {30'h0, SRC_PLL});
    rate("prescale_crystal", 2000, 24);
    bus(1'b1, ADDR_PLLCTL, 32'h0000_0003);
    rate("prescale_internal", 2000, 36);
    bus(1'b1, ADDR_SYSCTL, {30'h0, SRC_WAKEUP});
    bus(1'b1, ADDR_PLLCTL, 32'h0001_0070);
    bus(1'b1, ADDR_SYSCTL, {30'h0, SRC_PLL});
    rd_chk(ADDR_STATUS, {LOWER_STEP_MIN, 13'h0000, 1'b1, SRC_PLL}, "status_pll_on");
    wait_lock();
    bus(1'b0, ADDR_STATUS, 32'h0);
    check_in("lower_step", int'(q[31:16]), LOWER_STEP_MIN, LOWER_STEP_MAX);
    rate("pll_lower", 2560, 128);
    // one band up at a time keeps the supply steady
    bus(1'b1, ADDR_PLLCTL, 32'h0002_0274);
    bus(1'b0, ADDR_STATUS, 32'h0);
    s1 = int'(q[31:16]);
    bus(1'b0, ADDR_STATUS, 32'h0);
    s2 = int'(q[31:16]);
    check_in("step_slew", s2 - s1, 1, 8);
    k = 0;
    while (s2 < int'(UPPER_STEP_MIN) && k < 1500)
    begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      s2 = int'(q[31:16]);
      k++;
    end
    wait_lock();
    bus(1'b0, ADDR_STATUS, 32'h0);
    check_in("upper_step", int'(q[31:16]), UPPER_STEP_MIN, UPPER_STEP_MAX);
    rate("pll_upper", 2560, 64);
    bus(1'b1, ADDR_SYSCTL, {30'h0, SRC_WAKEUP});
    rd_chk(ADDR_STATUS, {UPPER_STEP_MIN, 16'h0000}, "status_pll_off");
    check("pll_enable_off", pll_en, 32'h0000_0000);
    check("pll_lock_off", pll_lk, 32'h0000_0000);
    report_and_stop();
  end
endmodule : testbench
